// File: verification/tb_timer_capture_compare_pwm.sv
// Self-checking testbench of the timer block.
`timescale 1ns/1ps
module tb_timer_capture_compare_pwm;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, fclk, xclk;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, rs;
  logic halt = 1'b0, ext_run = 1'b0;
  logic [1:0] drv = 2'h0, pin_in, pin_out, pin_oe;
  int err_total = 0, n_checks = 0, cyc = 0, rcyc = 0;
  tcp_top dut_u (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .debug_halt_mode(halt), .fixed_clock(fclk), .external_count_clock(xclk),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe));
  tcp_pins part_u (.aclk, .ext_run, .pin_drive(drv), .pin_out, .pin_oe,
    .fixed_clock(fclk), .external_count_clock(xclk), .channel_pin_in(pin_in));
  initial forever #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int w;
    w = $urandom_range(2);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    bready <= (w == 0);
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      w--;
      if (w == 0) bready <= 1'b1;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int w;
    w = $urandom_range(2);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= (w == 0);
    forever begin
      @(posedge aclk);
      if (arvalid && arready) rcyc = cyc;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      w--;
      if (w == 0) rready <= 1'b1;
    end
    q = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  function automatic logic [7:0] cc(input int n);
    return 8'(tcp_pkg::ADDR_CH_BASE + tcp_pkg::ADDR_CH_STRIDE * n);
  endfunction
  task automatic meas(input int ch, output int per, output int hi);
    int s0;
    s0 = 0;
    per = 0;
    hi = 0;
    while (pin_out[ch] !== 1'b0) @(posedge aclk);
    while (pin_out[ch] !== 1'b1) @(posedge aclk);
    forever begin
      hi += pin_out[ch];
      @(posedge aclk);
      per++;
      if (pin_out[ch] === 1'b0) s0 = 1;
      else if (s0) break;
    end
  endtask
  initial begin
    int m, v, p, h, e, t, pr;
    int dv[4];
    int lv[4];
    logic [15:0] c0, dq;
    void'($urandom(51));
    dv = '{0, 1, 4, 8};
    lv = '{1, 0, 1, 0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i < 3 ? 4 * i : 4 * i + 4));
      chk("reset_reg", 32'h0, q);
    end
    chk("reset_oe", 2'h0, pin_oe);
    rd(8'hFC);
    chk("bad_rd", tcp_pkg::RESP_SLVERR, rs);
    wr(8'hFC, 32'h1, 4'hF);
    chk("bad_wr", tcp_pkg::RESP_SLVERR, rs);
    $display("reset test done");
    ext_run <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(tcp_pkg::ADDR_STATUS, 32'(s) << tcp_pkg::STS_CLK_LSB, 4'h1);
      rd(tcp_pkg::ADDR_COUNT);
      c0 = q[15:0];
      t = rcyc;
      repeat (200) @(posedge aclk);
      rd(tcp_pkg::ADDR_COUNT);
      dq = q[15:0] - c0;
      e = s ? (rcyc - t) / dv[s] : 0;
      chk("count_rate", 1, s < 2 ? dq == e : dq + 1 >= e && dq <= e + 1);
    end
    pr = 1 + $urandom_range(5);
    wr(tcp_pkg::ADDR_STATUS, 32'h8 | pr, 4'h1);
    rd(tcp_pkg::ADDR_COUNT);
    c0 = q[15:0];
    t = rcyc;
    repeat (200) @(posedge aclk);
    rd(tcp_pkg::ADDR_COUNT);
    dq = q[15:0] - c0;
    e = (rcyc - t) >> pr;
    chk("presc_rate", 1, dq + 1 >= e && dq <= e + 1);
    ext_run <= 1'b0;
    wr(tcp_pkg::ADDR_STATUS, 32'h8, 4'h1);
    wr(tcp_pkg::ADDR_COUNT, $urandom, 4'h2);
    t = cyc;
    rd(tcp_pkg::ADDR_COUNT);
    chk("count_clear", 1, q <= rcyc - t + 2);
    halt <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(tcp_pkg::ADDR_COUNT);
    c0 = q[15:0];
    repeat (50) @(posedge aclk);
    rd(tcp_pkg::ADDR_COUNT);
    chk("halt_freeze", c0, q[15:0]);
    halt <= 1'b0;
    repeat (20) @(posedge aclk);
    rd(tcp_pkg::ADDR_COUNT);
    chk("halt_resume", 1, q[15:0] != c0);
    $display("counter test done");
    m = 8 + $urandom_range(24);
    v = 1 + $urandom_range(m - 2);
    wr(tcp_pkg::ADDR_MODULO, m, 4'hF);
    wr(cc(0) + tcp_pkg::ADDR_CH_VALUE, v, 4'hF);
    wr(cc(1) + tcp_pkg::ADDR_CH_VALUE, v, 4'hF);
    wr(cc(0), 32'h28, 4'hF);
    wr(cc(1), 32'h34, 4'hF);
    meas(0, p, h);
    chk("pwm_align", 0, pin_out[1]);
    chk("pwm_period", m + 1, p);
    chk("pwm_high", v, h);
    meas(1, p, h);
    chk("pwm_low_true", m + 1 - v, h);
    chk("pwm_oe", 2'h3, pin_oe);
    wr(tcp_pkg::ADDR_STATUS, 32'h28, 4'h1);
    meas(0, p, h);
    chk("center_aligned_pulse_period", 2 * m, p);
    chk("center_aligned_pulse_high", 2 * v, h);
    meas(1, p, h);
    chk("center_aligned_pulse_low_true", 2 * m - 2 * v, h);
    halt <= 1'b1;
    repeat (3) @(posedge aclk);
    p = pin_out;
    repeat (40) @(posedge aclk);
    chk("halt_pins", p, pin_out);
    halt <= 1'b0;
    rd(tcp_pkg::ADDR_STATUS);
    chk("ovf_set", 1, q[7]);
    wr(tcp_pkg::ADDR_STATUS, 32'h80, 4'h1);
    rd(tcp_pkg::ADDR_STATUS);
    chk("ovf_keep", 1, q[7]);
    chk("clk_off_oe", 2'h0, pin_oe);
    wr(tcp_pkg::ADDR_STATUS, 32'h0, 4'h1);
    rd(tcp_pkg::ADDR_STATUS);
    chk("ovf_clear", 0, q[7]);
    $display("pwm test done");
    wr(cc(0), 32'h0, 4'hF);
    wr(cc(1), 32'h0, 4'hF);
    wr(tcp_pkg::ADDR_STATUS, 32'hF, 4'h1);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      wr(cc(0), i << 2, 4'hF);
      drv[0] <= 1'b1;
      repeat (8) @(posedge aclk);
      rd(cc(0));
      chk("cap_rise", 1, q[7] == (i % 2));
      if (i == 1) begin
        rd(cc(0) + tcp_pkg::ADDR_CH_VALUE);
        c0 = q[15:0];
        rd(tcp_pkg::ADDR_COUNT);
        dq = q[15:0] - c0;
        chk("cap_value", 1, dq <= 1);
      end
      wr(cc(0), i << 2, 4'hF);
      drv[0] <= 1'b0;
      repeat (8) @(posedge aclk);
      rd(cc(0));
      chk("cap_fall", 1, q[7] == (i >= 2));
    end
    $display("capture test done");
    wr(tcp_pkg::ADDR_STATUS, 32'h8, 4'h1);
    wr(tcp_pkg::ADDR_MODULO, 32'h3F, 4'hF);
    wr(cc(0) + tcp_pkg::ADDR_CH_VALUE, $urandom_range(63), 4'hF);
    for (int i = 0; i < 4; i++) begin
      e = 3 - i;
      wr(cc(0), 32'h10 | e << 2, 4'hF);
      t = 0;
      do begin
        rd(cc(0));
        t++;
      end while (q[7] !== 1'b1 && t < 60);
      repeat (2) @(posedge aclk);
      chk("cmp_flag", 1, q[7]);
      chk("cmp_oe", e != 0, pin_oe[0]);
      if (e != 0) chk("cmp_pin", lv[i], pin_out[0]);
    end
    $display("compare test done");
    test_done();
  end
endmodule

// File: verification/tcp_pins.sv
// Model of the pins and clock sources outside the timer block.
`timescale 1ns/1ps
module tcp_pins (
  input wire logic aclk,
  input wire logic ext_run,
  input wire logic [tcp_pkg::NUM_CH-1:0] pin_drive,
  input wire logic [tcp_pkg::NUM_CH-1:0] pin_out,
  input wire logic [tcp_pkg::NUM_CH-1:0] pin_oe,
  output logic fixed_clock,
  output logic external_count_clock,
  output logic [tcp_pkg::NUM_CH-1:0] channel_pin_in
);
  int n = 0;
  initial fixed_clock = 1'b0;
  initial external_count_clock = 1'b0;
  always @(posedge aclk) begin
    n <= n + 1;
    fixed_clock <= n[1];
    external_count_clock <= ext_run & n[2];
  end
  assign channel_pin_in = (pin_oe & pin_out) | (~pin_oe & pin_drive);
endmodule

// File: verification/tcp_sva.sv
// Concurrent checks on the bus and pin ports of the timer block.
`timescale 1ns/1ps
module tcp_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [7:0] araddr,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic debug_halt_mode,
  input wire logic [tcp_pkg::NUM_CH-1:0] channel_pin_out,
  input wire logic [tcp_pkg::NUM_CH-1:0] channel_pin_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_RESET_FREE: assert property ($rose(aresetn) |-> channel_pin_oe == '0 && !bvalid)
    else $error("pins or response active after reset");
  AST_W_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  AST_B_STAND: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_R_STAND: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_R_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  AST_BAD_READ: assert property (arvalid && arready && araddr == 8'hFC |=>
    rresp == tcp_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read answered");
  AST_HALT_FREEZE: assert property (debug_halt_mode [*6] |-> $stable(channel_pin_out))
    else $error("pin moved during halt");
  AST_READ_KEEPS: assert property (arvalid && arready && !awvalid && !bvalid |=>
    $stable(channel_pin_oe))
    else $error("read changed pin enables");
  cover property (bvalid && bready);
  cover property (rvalid && rresp == tcp_pkg::RESP_SLVERR);
  cover property (debug_halt_mode [*6]);
endmodule
bind tcp_top tcp_sva sva_u (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
  .debug_halt_mode, .channel_pin_out, .channel_pin_oe);

// File: verilog/tcp_channel.sv
// One timer channel: capture, compare and pulse output logic.
`timescale 1ns/1ps
module tcp_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic center,
  input wire logic clock_on,
  input wire logic [1:0] mode,
  input wire logic [1:0] edge_sel,
  input wire logic [15:0] compare_value,
  input wire logic [15:0] count,
  input wire logic count_moved,
  input wire logic count_down,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic capture_event,
  output logic flag_event
);
  typedef struct packed {
    logic sync_a;
    logic sync_b;
    logic last;
    logic level;
    logic oe;
  } tcp_ch_state_t;

  tcp_ch_state_t s;
  tcp_ch_state_t next_s;
  tcp_pkg::tcp_func_t func;
  logic match;
  logic rise;
  logic fall;
  logic sw_timer;

  always_comb begin
    next_s = s;
    next_s.sync_a = pin_in;
    next_s.sync_b = s.sync_a;
    next_s.last = s.sync_b;
    if (!clock_on || edge_sel == tcp_pkg::EDGE_OFF) begin
      func = tcp_pkg::FN_OFF;
    end else if (center) begin
      func = tcp_pkg::FN_CENTER_PWM;
    end else if (mode[tcp_pkg::MODE_PWM_BIT]) begin
      func = tcp_pkg::FN_EDGE_PWM;
    end else if (mode == tcp_pkg::MODE_COMPARE) begin
      func = tcp_pkg::FN_COMPARE;
    end else begin
      func = tcp_pkg::FN_CAPTURE;
    end
    match = count_moved && (count == compare_value);
    rise = s.sync_b && !s.last;
    fall = !s.sync_b && s.last;
    sw_timer = clock_on && !center && (mode == tcp_pkg::MODE_COMPARE) &&
               (edge_sel == tcp_pkg::EDGE_OFF);
    capture_event = 1'b0;
    flag_event = sw_timer && match;
    unique case (func)
      tcp_pkg::FN_OFF: begin
      end
      tcp_pkg::FN_CAPTURE: begin
        capture_event = ((edge_sel == tcp_pkg::EDGE_RISE) && rise) ||
                        ((edge_sel == tcp_pkg::EDGE_FALL) && fall) ||
                        ((edge_sel == tcp_pkg::EDGE_ANY) && (rise || fall));
        flag_event = capture_event;
      end
      tcp_pkg::FN_COMPARE: begin
        flag_event = match;
        if (match) begin
          unique case (edge_sel)
            tcp_pkg::EDGE_RISE: next_s.level = !s.level;
            tcp_pkg::EDGE_FALL: next_s.level = 1'b0;
            tcp_pkg::EDGE_ANY: next_s.level = 1'b1;
            tcp_pkg::EDGE_OFF: next_s.level = s.level;
          endcase
        end
      end
      tcp_pkg::FN_EDGE_PWM: begin
        flag_event = match;
        if (count_moved && count == tcp_pkg::COUNT_ZERO) begin
          next_s.level = !edge_sel[0];
        end
        if (match) begin
          next_s.level = edge_sel[0];
        end
      end
      tcp_pkg::FN_CENTER_PWM: begin
        flag_event = match;
        if (match) begin
          next_s.level = count_down ? !edge_sel[0] : edge_sel[0];
        end
      end
    endcase
    next_s.oe = (func == tcp_pkg::FN_COMPARE) || (func == tcp_pkg::FN_EDGE_PWM) ||
                (func == tcp_pkg::FN_CENTER_PWM);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin_out = s.level;
  assign pin_oe = s.oe;
endmodule

// File: verilog/tcp_pkg.sv
// Shared constants and types of the timer capture compare pwm block.
package tcp_pkg;
  localparam int NUM_CH = 2;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_MODULO = 8'h08;
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h08;
  localparam logic [7:0] ADDR_CH_VALUE = 8'h04;
  localparam int STS_OVF_BIT = 7;
  localparam int STS_CENTER_BIT = 5;
  localparam int STS_CLK_LSB = 3;
  localparam int STS_PRESC_LSB = 0;
  localparam int CH_FLAG_BIT = 7;
  localparam int CH_MODE_LSB = 4;
  localparam int CH_EDGE_LSB = 2;
  localparam int MODE_PWM_BIT = 1;
  localparam logic [1:0] CLK_NONE = 2'h0;
  localparam logic [1:0] CLK_BUS = 2'h1;
  localparam logic [1:0] CLK_FIXED = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;
  localparam logic [1:0] MODE_CAPTURE = 2'h0;
  localparam logic [1:0] MODE_COMPARE = 2'h1;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hFFFF;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [6:0] PRESC_FULL = 7'h7F;
  localparam logic [6:0] PRESC_ONE = 7'h01;
  localparam logic [2:0] PRESC_TOP = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    FN_OFF, FN_CAPTURE, FN_COMPARE, FN_EDGE_PWM, FN_CENTER_PWM
  } tcp_func_t;
endpackage

// File: verilog/tcp_top.sv
// Timer with capture, compare and pulse channels behind an AXI4-Lite slave.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module tcp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic debug_halt_mode,
  input wire logic fixed_clock,
  input wire logic external_count_clock,
  input wire logic [tcp_pkg::NUM_CH-1:0] channel_pin_in,
  output logic [tcp_pkg::NUM_CH-1:0] channel_pin_out,
  output logic [tcp_pkg::NUM_CH-1:0] channel_pin_oe
);
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic ovf;
    logic ovf_armed;
    logic center;
    logic [1:0] clk_src;
    logic [2:0] presc;
    logic [6:0] presc_cnt;
    logic [15:0] count;
    logic down;
    logic moved;
    logic moved_down;
    logic [15:0] modulo;
    logic [tcp_pkg::NUM_CH-1:0][1:0] ch_mode;
    logic [tcp_pkg::NUM_CH-1:0][1:0] ch_edge;
    logic [tcp_pkg::NUM_CH-1:0] ch_flag;
    logic [tcp_pkg::NUM_CH-1:0][15:0] ch_value;
    logic [1:0] src_a;
    logic [1:0] src_b;
    logic [1:0] src_last;
  } tcp_top_state_t;

  tcp_top_state_t s;
  tcp_top_state_t next_s;
  logic [tcp_pkg::NUM_CH-1:0] capture_event;
  logic [tcp_pkg::NUM_CH-1:0] flag_event;
  logic src_tick;
  logic step;
  logic run;
  logic presc_hit;
  logic clock_on;
  logic ovf_event;
  logic [6:0] presc_mask;
  logic [15:0] top;
  logic do_write;
  logic rd_hit;
  logic wr_hit;
  logic [31:0] rd_word;

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  function automatic logic [7:0] ch_ctrl_addr(input int idx);
    return 8'(tcp_pkg::ADDR_CH_BASE + tcp_pkg::ADDR_CH_STRIDE * idx);
  endfunction

  always_comb begin
    next_s = s;
    // The first synchroniser stage feeds only the second stage.
    next_s.src_a = {external_count_clock, fixed_clock};
    next_s.src_b = s.src_a;
    next_s.src_last = s.src_b;
    unique case (s.clk_src)
      tcp_pkg::CLK_NONE: src_tick = 1'b0;
      tcp_pkg::CLK_BUS: src_tick = 1'b1;
      tcp_pkg::CLK_FIXED: src_tick = s.src_b[0] && !s.src_last[0];
      tcp_pkg::CLK_EXT: src_tick = s.src_b[1] && !s.src_last[1];
    endcase
    presc_mask = tcp_pkg::PRESC_FULL >> (tcp_pkg::PRESC_TOP - s.presc);
    // Wait mode has no gate here, so counting goes on in it.
    run = src_tick && !debug_halt_mode;
    presc_hit = (s.presc_cnt & presc_mask) == presc_mask;
    step = run && presc_hit;
    if (run) begin
      next_s.presc_cnt = s.presc_cnt + tcp_pkg::PRESC_ONE;
    end
    if (s.modulo == tcp_pkg::COUNT_ZERO || s.modulo == tcp_pkg::COUNT_FULL) begin
      top = tcp_pkg::COUNT_FULL;
    end else begin
      top = s.modulo;
    end
    ovf_event = 1'b0;
    next_s.moved = step;
    if (step) begin
      if (s.center) begin
        if (!s.down && s.count >= top) begin
          next_s.down = 1'b1;
          next_s.count = s.count - tcp_pkg::COUNT_ONE;
          ovf_event = 1'b1;
        end else if (s.down && s.count == tcp_pkg::COUNT_ZERO) begin
          next_s.down = 1'b0;
          next_s.count = s.count + tcp_pkg::COUNT_ONE;
        end else if (s.down) begin
          next_s.count = s.count - tcp_pkg::COUNT_ONE;
        end else begin
          next_s.count = s.count + tcp_pkg::COUNT_ONE;
        end
        next_s.moved_down = next_s.down;
      end else begin
        next_s.down = 1'b0;
        next_s.moved_down = 1'b0;
        if (s.count >= top) begin
          next_s.count = tcp_pkg::COUNT_ZERO;
          ovf_event = 1'b1;
        end else begin
          next_s.count = s.count + tcp_pkg::COUNT_ONE;
        end
      end
    end

    // The bus side takes one write and one read at a time.
    awready = !s.aw_got && !s.bvalid;
    wready = !s.w_got && !s.bvalid;
    arready = !s.rvalid;
    if (awvalid && awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end

    do_write = s.aw_got && s.w_got && !s.bvalid;
    wr_hit = 1'b0;
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      if (s.aw_addr == tcp_pkg::ADDR_STATUS) begin
        wr_hit = 1'b1;
        if (s.w_strb[0]) begin
          next_s.center = s.w_data[tcp_pkg::STS_CENTER_BIT];
          next_s.clk_src = s.w_data[tcp_pkg::STS_CLK_LSB +: 2];
          next_s.presc = s.w_data[tcp_pkg::STS_PRESC_LSB +: 3];
          if (s.ovf_armed && !s.w_data[tcp_pkg::STS_OVF_BIT]) begin
            next_s.ovf = 1'b0;
            next_s.ovf_armed = 1'b0;
          end
        end
      end
      if (s.aw_addr == tcp_pkg::ADDR_COUNT) begin
        wr_hit = 1'b1;
        if (|s.w_strb[1:0]) begin
          next_s.count = tcp_pkg::COUNT_ZERO;
          next_s.presc_cnt = '0;
          next_s.down = 1'b0;
          next_s.moved = 1'b0;
        end
      end
      if (s.aw_addr == tcp_pkg::ADDR_MODULO) begin
        wr_hit = 1'b1;
        next_s.modulo = merge16(s.modulo, s.w_data, s.w_strb);
      end
      for (int i = 0; i < tcp_pkg::NUM_CH; i++) begin
        if (s.aw_addr == ch_ctrl_addr(i)) begin
          wr_hit = 1'b1;
          if (s.w_strb[0]) begin
            next_s.ch_mode[i] = s.w_data[tcp_pkg::CH_MODE_LSB +: 2];
            next_s.ch_edge[i] = s.w_data[tcp_pkg::CH_EDGE_LSB +: 2];
            if (!s.w_data[tcp_pkg::CH_FLAG_BIT]) begin
              next_s.ch_flag[i] = 1'b0;
            end
          end
        end
        if (s.aw_addr == 8'(ch_ctrl_addr(i) + tcp_pkg::ADDR_CH_VALUE)) begin
          wr_hit = 1'b1;
          next_s.ch_value[i] = merge16(s.ch_value[i], s.w_data, s.w_strb);
        end
      end
      next_s.bresp = wr_hit ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
    end

    rd_hit = 1'b0;
    rd_word = '0;
    if (araddr == tcp_pkg::ADDR_STATUS) begin
      rd_hit = 1'b1;
      rd_word[tcp_pkg::STS_OVF_BIT] = s.ovf;
      rd_word[tcp_pkg::STS_CENTER_BIT] = s.center;
      rd_word[tcp_pkg::STS_CLK_LSB +: 2] = s.clk_src;
      rd_word[tcp_pkg::STS_PRESC_LSB +: 3] = s.presc;
    end
    if (araddr == tcp_pkg::ADDR_COUNT) begin
      rd_hit = 1'b1;
      rd_word[15:0] = s.count;
    end
    if (araddr == tcp_pkg::ADDR_MODULO) begin
      rd_hit = 1'b1;
      rd_word[15:0] = s.modulo;
    end
    for (int i = 0; i < tcp_pkg::NUM_CH; i++) begin
      if (araddr == ch_ctrl_addr(i)) begin
        rd_hit = 1'b1;
        rd_word[tcp_pkg::CH_FLAG_BIT] = s.ch_flag[i];
        rd_word[tcp_pkg::CH_MODE_LSB +: 2] = s.ch_mode[i];
        rd_word[tcp_pkg::CH_EDGE_LSB +: 2] = s.ch_edge[i];
      end
      if (araddr == 8'(ch_ctrl_addr(i) + tcp_pkg::ADDR_CH_VALUE)) begin
        rd_hit = 1'b1;
        rd_word[15:0] = s.ch_value[i];
      end
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_hit ? tcp_pkg::RESP_OKAY : tcp_pkg::RESP_SLVERR;
      if (araddr == tcp_pkg::ADDR_STATUS && s.ovf) begin
        next_s.ovf_armed = 1'b1;
      end
    end

    // Hardware events come last so that a set wins over a clear.
    if (ovf_event) begin
      next_s.ovf = 1'b1;
      next_s.ovf_armed = 1'b0;
    end
    for (int i = 0; i < tcp_pkg::NUM_CH; i++) begin
      if (capture_event[i]) begin
        next_s.ch_value[i] = s.count;
      end
      if (flag_event[i]) begin
        next_s.ch_flag[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.clk_src <= tcp_pkg::CLK_NONE;
    end else begin
      s <= next_s;
    end
  end

  // One channel per pin; all of them share the counter and its direction.
  assign clock_on = s.clk_src != tcp_pkg::CLK_NONE;

  genvar g;
  generate
    for (g = 0; g < tcp_pkg::NUM_CH; g++) begin : gen_ch
      tcp_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .center(s.center),
        .clock_on(clock_on),
        .mode(s.ch_mode[g]),
        .edge_sel(s.ch_edge[g]),
        .compare_value(s.ch_value[g]),
        .count(s.count),
        .count_moved(s.moved),
        .count_down(s.moved_down),
        .pin_in(channel_pin_in[g]),
        .pin_out(channel_pin_out[g]),
        .pin_oe(channel_pin_oe[g]),
        .capture_event(capture_event[g]),
        .flag_event(flag_event[g])
      );
    end
  endgenerate

  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
endmodule
